// [pkg/fsr_pkg.sv]
// Purpose: Constants and types for the fault supervisor with auto-retry.
// Assumes: 100 MHz system clock.
// Notes:   Long counts are defaults for top-level parameters.
package fsr_pkg;
  localparam int  CLK_NS      = 10;
  localparam real T_SLOW_MS   = 2.1;
  localparam real T_FAST_NS   = 100.0;
  localparam real T_OV_US     = 1.3;
  localparam real T_START_US  = 10.0;
  localparam real T_LEAD_US   = 100.0;
  localparam real T_CODE_KHZ  = 50.0;
  localparam real T_HOLD_MS   = 100.0;
  localparam int  SLOW_CYC    = int'($ceil(T_SLOW_MS * 1.0e6 / CLK_NS));
  localparam int  FAST_CYC    = int'($ceil(T_FAST_NS / CLK_NS));
  localparam int  OV_CYC      = int'($ceil(T_OV_US * 1.0e3 / CLK_NS));
  localparam int  START_CYC   = int'($ceil(T_START_US * 1.0e3 / CLK_NS));
  localparam int  LEAD_CYC    = int'($ceil(T_LEAD_US * 1.0e3 / CLK_NS));
  localparam int  PHASE_CYC   = int'($ceil(1.0e6 / (2.0 * T_CODE_KHZ * CLK_NS)));
  localparam int  HOLD_CYC    = int'($ceil(T_HOLD_MS * 1.0e6 / CLK_NS));
  localparam int  QW          = 18;
  localparam int  TW          = 24;
  // Register map
  localparam logic [7:0]  ADDR_CTRL    = 8'h00;
  localparam logic [7:0]  ADDR_STATUS  = 8'h04;
  localparam logic [7:0]  ADDR_STATE   = 8'h08;
  localparam int          CTRL_SUPP    = 0;
  localparam logic        CTRL_SUPP_RST = 1'b0;
  // Fault bit positions; code sent is position plus one
  localparam int  FLT_SLOW  = 0;
  localparam int  FLT_FAST  = 1;
  localparam int  FLT_OV    = 2;
  localparam int  FLT_TEMP  = 3;
  localparam int  FLT_RANGE = 4;
  localparam int  FLT_OPEN  = 5;
  localparam int  FLT_SHORT = 6;
  localparam int  FLT_FREQ  = 7;
  localparam int  FLT_TRIM  = 8;
  localparam int  NFLT      = 9;
  localparam logic [NFLT-1:0] TRIM_ONLY = 9'h100;
  // Asynchronous comparator inputs
  localparam int  CMP_LSOC  = 0;
  localparam int  CMP_OC5X  = 1;
  localparam int  CMP_TJ    = 2;
  localparam int  CMP_OV    = 3;
  localparam int  CMP_P4V5  = 4;
  localparam int  CMP_P3V95 = 5;
  localparam int  CMP_P0V5  = 6;
  localparam int  CMP_F0V15 = 7;
  localparam int  CMP_PIN   = 8;
  localparam int  NCMP      = 9;
  typedef enum logic [6:0] {
    ST_RUN     = 7'h01,
    ST_WAIT    = 7'h02,
    ST_LEAD    = 7'h04,
    ST_LOW     = 7'h08,
    ST_HIGH    = 7'h10,
    ST_HOLD    = 7'h20,
    ST_RELEASE = 7'h40
  } fsr_state_t;
endpackage : fsr_pkg

// [verilog/fsr_fault_supervisor.sv]
// Purpose: Fault qualification, pulse-code signalling and auto-retry.
// Assumes: Comparators are asynchronous; check and trim strobes share clk_sys.
// Notes:   The disable/fault pin is open drain: out is always low, oe pulls.
//
// The placing of the registers and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module fsr_fault_supervisor #(
  parameter int SlowCyc = fsr_pkg::SLOW_CYC,
  parameter int LeadCyc = fsr_pkg::LEAD_CYC,
  parameter int HoldCyc = fsr_pkg::HOLD_CYC
) (
  input  wire logic        clk_sys,
  input  wire logic        reset,
  input  wire logic        lowSideOn,
  input  wire logic        lsCurAboveLimit,
  input  wire logic        curAbove5xLimit,
  input  wire logic        tjAboveShutdown,
  input  wire logic        aboveInputOvervoltageThreshold,
  input  wire logic        progPinAbove4p5,
  input  wire logic        progPinAbove3p95,
  input  wire logic        progPinBelow0p5,
  input  wire logic        freqSetPinBelow0p15,
  input  wire logic        progCheckActive,
  input  wire logic        progCheckDone,
  input  wire logic        trimReadDone,
  input  wire logic        trimSane,
  input  wire logic        disableFaultPinIn,
  output logic             disableFaultPinOut,
  output logic             disableFaultPinOe,
  output logic             switchEnable,
  output logic             lowPowerMode,
  output logic             regulatorEnable,
  output logic             freqSetPinHold,
  input  wire logic [7:0]  regAddr,
  input  wire logic [31:0] regWrData,
  input  wire logic        regWr,
  input  wire logic        regRd,
  output logic [31:0]      regRdData
);
  import fsr_pkg::*;

  logic [NCMP-1:0] cmpRaw;
  logic [NCMP-1:0] syncA_r;
  logic [NCMP-1:0] syncB_r;
  logic [NCMP-1:0] syncC_r;
  logic [NCMP-1:0] cmpFilt_r;
  logic [2:0]      qCond;
  logic [2:0]      qHit;
  logic [QW-1:0]   qLim [3];
  logic [QW-1:0]   qCnt_r [3];
  logic [NFLT-1:0] fRaw;
  logic [NFLT-1:0] faultNow;
  logic [NFLT-1:0] faultSet_r;
  logic            anyFault;
  logic            trimErr_r;
  logic            suppSlow_r;
  logic            pinHigh;
  fsr_state_t      state_r;
  fsr_state_t      state_nxt;
  logic [TW-1:0]   tmr_r;
  logic            tmrDone;
  logic [3:0]      codeIdx_r;
  logic [3:0]      pulseCnt_r;
  logic [4:0]      nextHit;
  logic [3:0]      searchFrom;
  logic [31:0]     rdData_r;

  // Finds the lowest set fault at or above a position; bit 4 marks a hit
  function automatic logic [4:0] next_set(input logic [NFLT-1:0] mask,
                                          input logic [3:0] from);
    logic [4:0] res;
    res = 5'h00;
    for (int i = 0; i < NFLT; i++) begin
      if (!res[4] && mask[i] && (4'(i) >= from)) begin
        res = {1'b1, 4'(i)};
      end
    end
    return res;
  endfunction : next_set

  // Timer reload for each timed state, minus one for the load cycle
  function automatic logic [TW-1:0] dur_of(input fsr_state_t st);
    logic [TW-1:0] d;
    d = '0;
    case (st)
      ST_WAIT: d = TW'(START_CYC - 1);
      ST_LEAD: d = TW'(LeadCyc - 1);
      ST_LOW:  d = TW'(PHASE_CYC - 1);
      ST_HIGH: d = TW'(PHASE_CYC - 1);
      ST_HOLD: d = TW'(HoldCyc - 1);
      default: d = '0;
    endcase
    return d;
  endfunction : dur_of

  assign cmpRaw = {disableFaultPinIn, freqSetPinBelow0p15, progPinBelow0p5,
                   progPinAbove3p95, progPinAbove4p5, aboveInputOvervoltageThreshold,
                   tjAboveShutdown, curAbove5xLimit, lsCurAboveLimit};

  // First stage feeds only the second; a change counts once B and C agree
  for (genvar g = 0; g < NCMP; g++) begin : g_sync
    always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
        syncA_r[g]   <= 1'b0;
        syncB_r[g]   <= 1'b0;
        syncC_r[g]   <= 1'b0;
        cmpFilt_r[g] <= 1'b0;
      end else begin
        syncA_r[g] <= cmpRaw[g];
        syncB_r[g] <= syncA_r[g];
        syncC_r[g] <= syncB_r[g];
        if (syncB_r[g] == syncC_r[g]) begin
          cmpFilt_r[g] <= syncC_r[g];
        end
      end
    end
  end

  assign pinHigh = cmpFilt_r[CMP_PIN];

  // Low-side current is only counted while the low-side switch conducts; the 5x check always runs
  assign qCond[0] = cmpFilt_r[CMP_LSOC];
  assign qCond[1] = cmpFilt_r[CMP_OC5X];
  assign qCond[2] = cmpFilt_r[CMP_OV];
  assign qLim[0]  = QW'(SlowCyc);
  assign qLim[1]  = QW'(FAST_CYC + 1);
  assign qLim[2]  = QW'(OV_CYC + 1);

  for (genvar q = 0; q < 3; q++) begin : g_qual
    assign qHit[q] = (qCnt_r[q] == qLim[q]);
    always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
        qCnt_r[q] <= '0;
      end else if (q == 0 && !lowSideOn) begin
        qCnt_r[q] <= qCnt_r[q];
      end else if (!qCond[q]) begin
        qCnt_r[q] <= '0;
      end else if (!qHit[q]) begin
        qCnt_r[q] <= qCnt_r[q] + 1'b1;
      end
    end
  end

  assign fRaw[FLT_SLOW]  = qHit[0] & ~suppSlow_r;
  assign fRaw[FLT_FAST]  = qHit[1];
  assign fRaw[FLT_OV]    = qHit[2];
  assign fRaw[FLT_TEMP]  = cmpFilt_r[CMP_TJ];
  assign fRaw[FLT_RANGE] = progCheckActive & cmpFilt_r[CMP_P3V95] & ~cmpFilt_r[CMP_P4V5];
  assign fRaw[FLT_OPEN]  = progCheckDone & cmpFilt_r[CMP_P4V5];
  assign fRaw[FLT_SHORT] = cmpFilt_r[CMP_P0V5];
  assign fRaw[FLT_FREQ]  = cmpFilt_r[CMP_F0V15];
  assign fRaw[FLT_TRIM]  = trimErr_r;

  // A trim error masks every other condition
  assign faultNow = trimErr_r ? TRIM_ONLY : fRaw;
  assign anyFault = |faultNow;

  // No path clears this but reset, so retries keep reporting it
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      trimErr_r <= 1'b0;
    end else if (trimReadDone && !trimSane) begin
      trimErr_r <= 1'b1;
    end
  end

  assign tmrDone    = (tmr_r == '0);
  assign searchFrom = (state_r == ST_WAIT) ? 4'h0 : codeIdx_r + 4'h1;
  assign nextHit    = next_set(faultSet_r, searchFrom);

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_RUN: begin
        if (anyFault) begin
          state_nxt = ST_WAIT;
        end else if (!pinHigh) begin
          state_nxt = ST_RELEASE;
        end
      end
      ST_WAIT: begin
        if (tmrDone) begin
          state_nxt = ST_LEAD;
        end
      end
      ST_LEAD: begin
        if (tmrDone) begin
          state_nxt = ST_LOW;
        end
      end
      ST_LOW: begin
        if (tmrDone) begin
          // Separator follows the last low pulse so it stays one lead long
          if (pulseCnt_r == codeIdx_r && nextHit[4]) begin
            state_nxt = ST_LEAD;
          end else begin
            state_nxt = ST_HIGH;
          end
        end
      end
      ST_HIGH: begin
        if (tmrDone) begin
          if (pulseCnt_r != codeIdx_r) begin
            state_nxt = ST_LOW;
          end else begin
            state_nxt = ST_HOLD;
          end
        end
      end
      ST_HOLD: begin
        if (tmrDone) begin
          state_nxt = ST_RELEASE;
        end
      end
      ST_RELEASE: begin
        // An external low here keeps the device disabled
        if (pinHigh) begin
          state_nxt = anyFault ? ST_WAIT : ST_RUN;
        end
      end
      default: state_nxt = ST_RELEASE;
    endcase
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      state_r <= ST_RELEASE;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      tmr_r <= '0;
    end else if (state_nxt != state_r) begin
      tmr_r <= dur_of(state_nxt);
    end else if (!tmrDone) begin
      tmr_r <= tmr_r - 1'b1;
    end
  end

  // Codes are frozen at fault entry so a train is never altered mid-way
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      faultSet_r <= '0;
    end else if (state_nxt == ST_WAIT && state_r != ST_WAIT) begin
      faultSet_r <= faultNow;
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      codeIdx_r  <= 4'h0;
      pulseCnt_r <= 4'h0;
    end else if (state_nxt == ST_LEAD && state_r != ST_LEAD) begin
      codeIdx_r <= nextHit[3:0];
    end else if (state_nxt == ST_LOW && state_r == ST_LEAD) begin
      pulseCnt_r <= 4'h0;
    end else if (state_nxt == ST_LOW && state_r == ST_HIGH) begin
      pulseCnt_r <= pulseCnt_r + 4'h1;
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      disableFaultPinOe <= 1'b0;
      switchEnable      <= 1'b0;
      lowPowerMode      <= 1'b0;
    end else begin
      disableFaultPinOe <= (state_nxt == ST_WAIT) || (state_nxt == ST_LOW) ||
                           (state_nxt == ST_HOLD);
      switchEnable      <= (state_nxt == ST_RUN);
      lowPowerMode      <= (state_nxt == ST_HOLD) || (state_nxt == ST_RELEASE);
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      regulatorEnable <= 1'b0;
      freqSetPinHold  <= 1'b0;
    end else begin
      regulatorEnable <= 1'b1;
      freqSetPinHold  <= 1'b1;
    end
  end

  assign disableFaultPinOut = 1'b0;

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      suppSlow_r <= CTRL_SUPP_RST;
    end else if (regWr && regAddr == ADDR_CTRL) begin
      suppSlow_r <= regWrData[CTRL_SUPP];
    end
  end

  // Read data stand only in the cycle after the strobe
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      rdData_r <= '0;
    end else if (!regRd) begin
      rdData_r <= '0;
    end else if (regAddr == ADDR_CTRL) begin
      rdData_r <= {31'h0, suppSlow_r};
    end else if (regAddr == ADDR_STATUS) begin
      rdData_r <= {7'h00, faultNow, 7'h00, faultSet_r};
    end else if (regAddr == ADDR_STATE) begin
      rdData_r <= {25'h0, state_r};
    end else begin
      rdData_r <= '0;
    end
  end

  assign regRdData = rdData_r;
endmodule : fsr_fault_supervisor
`default_nettype wire

// [tb/fsr_host_model.sv]
// Purpose: Host on the disable/fault pin: pull-up, forced disable, code reader.
// Assumes: Code phases last whole clock cycles.
// Notes:   A code is reported when the next lead or the hold-off low ends.
`timescale 1ns/1ps
`default_nettype none
module fsr_host_model #(
  parameter int LeadCyc = 50,
  parameter int HoldCyc = 200
) (
  input  wire logic       clk_sys,
  input  wire logic       reset,
  input  wire logic       pinOe,
  input  wire logic       holdLow,
  output logic            pinLevel,
  output logic            codeValid,
  output logic [3:0]      code
);
  int         runLen;
  logic       pinPrev;
  logic       seen;
  logic [3:0] cnt;
  // Released pin floats up to the pull-up level, never holds its last value
  assign pinLevel = !(pinOe || holdLow);
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      runLen    <= 0;
      pinPrev   <= 1'b1;
      seen      <= 1'b0;
      cnt       <= 4'h0;
      code      <= 4'h0;
      codeValid <= 1'b0;
    end else begin
      codeValid <= 1'b0;
      pinPrev   <= pinLevel;
      if (pinLevel == pinPrev) begin
        runLen <= runLen + 1;
      end else begin
        runLen <= 1;
        if (pinLevel && runLen == 1000) begin
          cnt <= cnt + 4'h1;
        end else if (pinLevel && runLen == HoldCyc) begin
          codeValid <= seen;
          code      <= cnt;
          seen      <= 1'b0;
          cnt       <= 4'h0;
        end else if (!pinLevel && runLen == LeadCyc) begin
          // The first lead only closes the start delay, later ones close a code
          codeValid <= seen;
          code      <= cnt;
          seen      <= 1'b1;
          cnt       <= 4'h0;
        end
      end
    end
  end
endmodule : fsr_host_model
`default_nettype wire

// [tb/fsr_fault_supervisor_sva.sv]
// Purpose: Port-level assertions for the fault supervisor.
// Assumes: One clock domain, asynchronous active-high reset.
// Notes:   Run-length counters stand in for long repetitions.
`timescale 1ns/1ps
`default_nettype none
module fsr_sva #(
  parameter int SlowCyc = 20,
  parameter int LeadCyc = 50,
  parameter int HoldCyc = 200
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic curAbove5xLimit,
  input wire logic aboveInputOvervoltageThreshold,
  input wire logic tjAboveShutdown,
  input wire logic trimReadDone,
  input wire logic trimSane,
  input wire logic disableFaultPinOut,
  input wire logic disableFaultPinOe,
  input wire logic switchEnable,
  input wire logic lowPowerMode,
  input wire logic regulatorEnable,
  input wire logic freqSetPinHold
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  int oeHi;
  int oeLo;
  int fastCnt;
  int ovCnt;
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      oeHi    <= 0;
      oeLo    <= 0;
      fastCnt <= 0;
      ovCnt   <= 0;
    end else begin
      oeHi    <= disableFaultPinOe ? oeHi + 1 : 0;
      oeLo    <= disableFaultPinOe ? 0 : oeLo + 1;
      fastCnt <= curAbove5xLimit ? fastCnt + 1 : 0;
      ovCnt   <= aboveInputOvervoltageThreshold ? ovCnt + 1 : 0;
    end
  end
  sequence trimBad;
    trimReadDone && !trimSane;
  endsequence
  sequence tempHeld;
    tjAboveShutdown [*8];
  endsequence
  a_pin_open_drain: assert property (disableFaultPinOut == 1'b0)
    else $error("pin output not low");
  a_pull_no_switch: assert property (disableFaultPinOe |-> !switchEnable)
    else $error("switching while pin pulled");
  a_idle_no_switch: assert property (lowPowerMode |-> !switchEnable)
    else $error("switching in low power");
  a_supply_kept: assert property (!reset |=> regulatorEnable && freqSetPinHold)
    else $error("regulator or frequency pin dropped");
  a_fast_stop: assert property (fastCnt == 20 |-> !switchEnable)
    else $error("fast overcurrent not acted on");
  a_ov_stop: assert property (ovCnt == 150 |-> !switchEnable)
    else $error("overvoltage not acted on");
  a_temp_stop: assert property (tempHeld |-> !switchEnable)
    else $error("thermal fault not acted on");
  a_trim_stop: assert property (trimBad |-> ##[1:4] !switchEnable)
    else $error("trim error not acted on");
  a_high_width: assert property ($fell(disableFaultPinOe) |-> oeHi == 1000 || oeHi == HoldCyc)
    else $error("pulldown phase length wrong");
  a_low_width: assert property ($rose(disableFaultPinOe) && !$past(lowPowerMode) && !$past(switchEnable)
    |-> oeLo == 1000 || oeLo == LeadCyc)
    else $error("released phase length wrong");
  a_restart_path: assert property ($rose(switchEnable) |-> $past(lowPowerMode))
    else $error("switching resumed without release");
endmodule : fsr_sva
`default_nettype wire

// [tb/tb.sv]
// Purpose: Self-checking bench for the fault supervisor.
// Assumes: Short lead, hold-off and slow counts.
// Notes:   Reads and decoded codes share one queue of expectations.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin error_cnt++; $display("[FAIL] %s exp %0h got %0h", n, e, g); end end
module tb;
  import fsr_pkg::*;
  logic        clk_sys, reset, holdLow, pin, codeValid, rdPend, oe, sw, lp, regEn, fHold;
  logic        trimReadDone, trimSane, regWr, regRd;
  logic [3:0]  code;
  logic [7:0]  regAddr;
  logic [10:0] st;
  logic [31:0] regWrData, regRdData, ex;
  logic [31:0] q[$];
  int          error_cnt = 0;
  int          compares = 0;
  logic [10:0] stim [7] = '{11'h101, 11'h002, 11'h008, 11'h084, 11'h220, 11'h430, 11'h040};
  logic [8:0]  mask [7] = '{9'h001, 9'h002, 9'h004, 9'h088, 9'h010, 9'h020, 9'h040};
  fsr_fault_supervisor #(.SlowCyc(20), .LeadCyc(50), .HoldCyc(200)) dut_u (
    .clk_sys, .reset, .lowSideOn(st[8]), .lsCurAboveLimit(st[0]), .curAbove5xLimit(st[1]),
    .tjAboveShutdown(st[2]), .aboveInputOvervoltageThreshold(st[3]), .progPinAbove4p5(st[4]),
    .progPinAbove3p95(st[5]), .progPinBelow0p5(st[6]), .freqSetPinBelow0p15(st[7]),
    .progCheckActive(st[9]), .progCheckDone(st[10]), .trimReadDone, .trimSane,
    .disableFaultPinIn(pin), .disableFaultPinOut(), .disableFaultPinOe(oe), .switchEnable(sw),
    .lowPowerMode(lp), .regulatorEnable(regEn), .freqSetPinHold(fHold), .regAddr, .regWrData, .regWr,
    .regRd, .regRdData);
  fsr_host_model #(.LeadCyc(50), .HoldCyc(200)) host_u (
    .clk_sys, .reset, .pinOe(oe), .holdLow, .pinLevel(pin), .codeValid, .code);
  function automatic logic [31:0] popx();
    return q.size() ? q.pop_front() : 32'hx;
  endfunction : popx
  task wrap_up();
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : wrap_up
  task bus(input logic w, input logic r, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    regWr     <= w;
    regRd     <= r;
    regAddr   <= a;
    regWrData <= d;
  endtask : bus
  task rd(input logic [7:0] a, input logic [31:0] e);
    q.push_back(e);
    bus(1'b0, 1'b1, a, 32'h0);
  endtask : rd
  task waitSw(input logic v);
    int n;
    n = 0;
    while (sw !== v && n < 40000) begin
      @(posedge clk_sys);
      n++;
    end
    `CHK("switch", v, sw)
  endtask : waitSw
  // Held long enough to pass every qualification delay, gone before retry
  task fault(input logic [10:0] s);
    @(posedge clk_sys);
    st <= s;
    repeat (160) @(posedge clk_sys);
    st <= s | 11'h100;
    @(posedge clk_sys);
    st <= (s | 11'h100) & 11'h500;
    // Let the synchronisers and counters drain before the next step
    repeat (8) @(posedge clk_sys);
  endtask : fault
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    rdPend <= regRd;
    if (rdPend) begin
      ex = popx();
      `CHK("read", ex, regRdData)
    end
    if (codeValid) begin
      ex = popx();
      `CHK("code", ex, {28'h0, code})
    end
  end
  initial begin
    repeat (150000) @(posedge clk_sys);
    error_cnt++;
    wrap_up();
  end
  initial begin
    void'($urandom(63));
    {holdLow, st, trimReadDone, trimSane, regWr, regRd, regAddr, regWrData} = '0;
    reset = 1'b1;
    repeat (5) @(posedge clk_sys);
    reset <= 1'b0;
    rd(ADDR_CTRL, 32'h0);
    rd(8'h0c + 8'($urandom % 200), 32'h0);
    bus(1'b1, 1'b0, ADDR_CTRL, 32'h1);
    bus(1'b0, 1'b0, ADDR_CTRL, 32'h0);
    trimSane <= 1'b1;
    trimReadDone <= 1'b1;
    @(posedge clk_sys);
    trimReadDone <= 1'b0;
    waitSw(1'b1);
    fault(11'h101);
    rd(ADDR_STATE, 32'h1);
    bus(1'b1, 1'b0, ADDR_CTRL, 32'h0);
    bus(1'b0, 1'b0, ADDR_CTRL, 32'h0);
    holdLow <= 1'b1;
    waitSw(1'b0);
    rd(ADDR_STATE, 32'h40);
    bus(1'b0, 1'b0, ADDR_CTRL, 32'h0);
    holdLow <= 1'b0;
    waitSw(1'b1);
    for (int i = 0; i < 7; i++) begin
      for (int b = 0; b < NFLT; b++) begin
        if (mask[i][b]) q.push_back(32'(b + 1));
      end
      fault(stim[i]);
      `CHK("stop", 1'b0, sw)
      waitSw(1'b1);
      rd(ADDR_STATUS, {23'h0, mask[i]});
      bus(1'b0, 1'b0, ADDR_CTRL, 32'h0);
      repeat ($urandom % 8) @(posedge clk_sys);
    end
    // Thermal fault rides along so masking by the trim error is seen
    q.push_back(32'h9);
    @(posedge clk_sys);
    trimSane <= 1'b0;
    trimReadDone <= 1'b1;
    st[2] <= 1'b1;
    @(posedge clk_sys);
    trimReadDone <= 1'b0;
    repeat (40000) if (q.size() != 0) @(posedge clk_sys);
    `CHK("trim codes", 0, q.size())
    `CHK("low power", 1'b1, lp)
    repeat (200) @(posedge clk_sys);
    `CHK("trim held", 1'b0, sw)
    `CHK("regulator", 2'b11, {regEn, fHold})
    wrap_up();
  end
endmodule : tb
bind fsr_fault_supervisor fsr_sva #(.SlowCyc(SlowCyc), .LeadCyc(LeadCyc), .HoldCyc(HoldCyc)) sva_u (
  .clk_sys, .reset, .curAbove5xLimit, .aboveInputOvervoltageThreshold, .tjAboveShutdown,
  .trimReadDone, .trimSane, .disableFaultPinOut, .disableFaultPinOe, .switchEnable,
  .lowPowerMode, .regulatorEnable, .freqSetPinHold);
`default_nettype wire
